//--- verilog/lls_pkg.sv
package lls_pkg;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_T1     = 8'h04;
  localparam logic [7:0] OFS_LIM    = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;

  localparam int CTRL_CONNECT = 0;
  localparam int CTRL_BUSY    = 1;
  localparam int CTRL_FRMR    = 2;
  localparam int LIM_N1       = 0;
  localparam int LIM_N2       = 8;
  localparam int ADDR_DST     = 0;
  localparam int ADDR_SRC     = 16;
  localparam int ST_STATE     = 0;
  localparam int ST_PBUSY     = 4;
  localparam int ST_T1RUN     = 5;
  localparam int ST_VS        = 8;
  localparam int ST_VR        = 12;
  localparam int ST_VA        = 16;
  localparam int ST_RETRY     = 24;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] T1_RST   = 32'h0000_0010;
  localparam logic [31:0] LIM_RST  = 32'h0000_0A0A;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  localparam logic [2:0] WIN_MAX     = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    LS_DISC  = 4'h1,
    LS_SETUP = 4'h2,
    LS_XFER  = 4'h4,
    LS_RECOV = 4'h8
  } lls_state_e;

  typedef enum logic [2:0] {
    FK_I     = 3'h0,
    FK_RR    = 3'h1,
    FK_RNR   = 3'h2,
    FK_REJ   = 3'h3,
    FK_SABM  = 3'h4,
    FK_UA    = 3'h5,
    FK_OTHER = 3'h7
  } lls_kind_e;

  typedef struct packed {
    lls_kind_e  kind;
    logic [2:0] ns;
    logic [2:0] nr;
    logic       pf;
    logic       fcs_ok;
    logic       empty;
  } lls_rx_s;

  typedef struct packed {
    logic [15:0] dst;
    logic [15:0] src;
    lls_kind_e   kind;
    logic [2:0]  ns;
    logic [2:0]  nr;
    logic        pf;
  } lls_tx_s;

endpackage

//--- verilog/lls_t1_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lls_t1_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] period,
  output logic             running,
  output logic             expire
);
  logic [15:0] count_r;
  logic        run_r;
  logic        exp_r;

  // Start wins over stop, so a restart on acknowledgement rearms cleanly.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= 16'h0000;
      run_r   <= 1'b0;
      exp_r   <= 1'b0;
    end else begin
      exp_r <= 1'b0;
      if (start) begin
        count_r <= period;
        run_r   <= 1'b1;
      end else if (stop) begin
        run_r <= 1'b0;
      end else if (run_r && tick) begin
        if (count_r <= 16'h0001) begin
          run_r <= 1'b0;
          exp_r <= 1'b1;
        end else begin
          count_r <= count_r - 16'h0001;
        end
      end
    end
  end

  assign running = run_r;
  assign expire  = exp_r;
endmodule
`default_nettype wire

//--- verilog/lls_link_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module lls_link_sequencer (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            proto_tick,
  input  wire logic            rx_valid,
  input  wire lls_pkg::lls_rx_s rx_frame,
  output logic                 tx_valid,
  input  wire logic            tx_ready,
  output lls_pkg::lls_tx_s     tx_frame,
  input  wire logic            i_avail,
  output logic                 i_take,
  output logic [2:0]           i_seq,
  output logic                 up_valid,
  output logic                 up_empty
);
  // ==========================================================================
  // Registers and state
  // ==========================================================================
  logic [31:0]         ctrl_r, t1_cfg_r, lim_r, addr_r;
  logic                connect_r;
  lls_pkg::lls_state_e state_r;
  logic [2:0]          vs_r, vr_r, va_r, x_r, top_r;
  logic [7:0]          retry_r;
  logic                peer_busy_r, busy_d_r, rej_out_r;
  logic                ua_p_r, sabm_p_r, fr_p_r, rej_p_r, rnr_p_r, rr_p_r, poll_p_r;
  logic                tick_s1_r, tick_s2_r, tick_s3_r;
  logic                tx_valid_r, i_take_r, up_valid_r, up_empty_r;
  logic [2:0]          i_seq_r;
  lls_pkg::lls_tx_s    tx_r, nxt;
  logic                ld_ua, ld_sabm, ld_fr, ld_rej, ld_rnr, ld_rr, ld_poll, ld_i, ld_any;
  logic                t1_run, t1_exp, t1_start, t1_stop;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic       busy, frmr, tick, rx_go, conn, in_setup, in_xfer, in_recov;
  logic       rx_i, rx_s, rx_rr, rx_rnr, rx_rej, rx_sabm, rx_ua;
  logic [2:0] rx_nr;
  logic [7:0] n1, n2;
  logic       new_ack, i_accept, i_oos, win_open, i_ok, can_load, limit_hit, recov_hit;

  assign busy      = ctrl_r[lls_pkg::CTRL_BUSY];
  assign frmr      = ctrl_r[lls_pkg::CTRL_FRMR];
  assign n1        = lim_r[lls_pkg::LIM_N1 +: 8];
  assign n2        = lim_r[lls_pkg::LIM_N2 +: 8];
  assign tick      = tick_s2_r & ~tick_s3_r;
  assign in_setup  = (state_r == lls_pkg::LS_SETUP);
  assign in_xfer   = (state_r == lls_pkg::LS_XFER);
  assign in_recov  = (state_r == lls_pkg::LS_RECOV);
  assign conn      = in_xfer | in_recov;
  // Frames with a bad check sequence are dropped without any action.
  assign rx_go     = rx_valid & rx_frame.fcs_ok;
  assign rx_nr     = rx_frame.nr;
  assign rx_i      = rx_go && rx_frame.kind == lls_pkg::FK_I;
  assign rx_rr     = rx_go && rx_frame.kind == lls_pkg::FK_RR;
  assign rx_rnr    = rx_go && rx_frame.kind == lls_pkg::FK_RNR;
  assign rx_rej    = rx_go && rx_frame.kind == lls_pkg::FK_REJ;
  assign rx_sabm   = rx_go && rx_frame.kind == lls_pkg::FK_SABM;
  assign rx_ua     = rx_go && rx_frame.kind == lls_pkg::FK_UA;
  assign rx_s      = rx_rr | rx_rnr | rx_rej;
  assign new_ack   = conn && (rx_i || rx_s) && rx_nr != va_r
                     && 3'(rx_nr - va_r) <= 3'(top_r - va_r);
  assign i_accept  = conn && rx_i && rx_frame.ns == vr_r && !busy;
  assign i_oos     = conn && rx_i && rx_frame.ns != vr_r && !busy;
  assign recov_hit = in_recov && rx_s && rx_frame.pf
                     && 3'(rx_nr - va_r) <= 3'(x_r - va_r);
  assign win_open  = 3'(vs_r - va_r) != lls_pkg::WIN_MAX;
  assign limit_hit = conn && retry_r >= n2;
  // Local busy does not stop sending; frame-reject mode does, and a busy peer does once a frame is outstanding.
  assign i_ok      = in_xfer && !frmr && win_open && (vs_r != top_r || i_avail)
                     && (!peer_busy_r || vs_r == va_r);
  assign can_load  = !tx_valid_r || tx_ready;

  // ==========================================================================
  // Protocol tick synchroniser
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
    end else begin
      tick_s1_r <= proto_tick;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
    end
  end

  // ==========================================================================
  // Transmit scheduler
  // ==========================================================================
  always_comb begin
    nxt      = '0;
    nxt.dst  = addr_r[lls_pkg::ADDR_DST +: 16];
    nxt.src  = addr_r[lls_pkg::ADDR_SRC +: 16];
    nxt.kind = busy ? lls_pkg::FK_RNR : lls_pkg::FK_RR;
    nxt.ns   = vs_r;
    nxt.nr   = vr_r;
    ld_ua    = 1'b0;
    ld_sabm  = 1'b0;
    ld_fr    = 1'b0;
    ld_rej   = 1'b0;
    ld_rnr   = 1'b0;
    ld_rr    = 1'b0;
    ld_poll  = 1'b0;
    ld_i     = 1'b0;
    ld_any   = can_load;
    if (!can_load) begin
      ld_any = 1'b0;
    end else if (ua_p_r) begin
      nxt.kind = lls_pkg::FK_UA;
      nxt.pf   = 1'b1;
      ld_ua    = 1'b1;
    end else if (sabm_p_r) begin
      nxt.kind = lls_pkg::FK_SABM;
      nxt.pf   = 1'b1;
      ld_sabm  = 1'b1;
    end else if (fr_p_r) begin
      nxt.pf = 1'b1;
      ld_fr  = 1'b1;
    end else if (rej_p_r) begin
      nxt.kind = lls_pkg::FK_REJ;
      ld_rej   = 1'b1;
    end else if (rnr_p_r) begin
      nxt.kind = lls_pkg::FK_RNR;
      ld_rnr   = 1'b1;
    end else if (rr_p_r && !i_ok) begin
      ld_rr = 1'b1;
    end else if (poll_p_r) begin
      nxt.pf  = 1'b1;
      ld_poll = 1'b1;
    end else if (i_ok) begin
      nxt.kind = lls_pkg::FK_I;
      ld_i     = 1'b1;
    end else begin
      ld_any = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_r <= 1'b0;
      tx_r       <= '0;
      i_take_r   <= 1'b0;
      i_seq_r    <= 3'h0;
    end else begin
      if (can_load) begin
        tx_valid_r <= ld_any;
      end
      if (ld_any) begin
        tx_r <= nxt;
      end
      i_take_r <= ld_i && vs_r == top_r;
      if (ld_i) begin
        i_seq_r <= vs_r;
      end
    end
  end

  // ==========================================================================
  // Pending frame flags; a new cause wins over the clear by sending
  // ==========================================================================
  logic busy_rise, busy_fall, exp_conn, exp_setup;
  assign busy_rise = busy & ~busy_d_r;
  assign busy_fall = ~busy & busy_d_r;
  assign exp_conn  = t1_exp && conn;
  assign exp_setup = t1_exp && in_setup && retry_r < n1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_d_r  <= 1'b0;
      rej_out_r <= 1'b0;
      ua_p_r    <= 1'b0;
      sabm_p_r  <= 1'b0;
      fr_p_r    <= 1'b0;
      rej_p_r   <= 1'b0;
      rnr_p_r   <= 1'b0;
      rr_p_r    <= 1'b0;
      poll_p_r  <= 1'b0;
    end else begin
      busy_d_r  <= busy;
      rej_out_r <= (i_oos & ~rej_out_r) | (rej_out_r & ~i_accept & ~rx_sabm);
      ua_p_r    <= rx_sabm | (ua_p_r & ~ld_ua);
      sabm_p_r  <= connect_r | exp_setup | limit_hit | (sabm_p_r & ~ld_sabm);
      fr_p_r    <= (conn && rx_s && rx_frame.pf) | (fr_p_r & ~ld_fr);
      rej_p_r   <= (i_oos & ~rej_out_r) | (rej_p_r & ~ld_rej);
      rnr_p_r   <= busy_rise | (conn & rx_i & busy) | (rnr_p_r & ~ld_rnr);
      rr_p_r    <= i_accept | busy_fall
                   | (rr_p_r & ~(ld_rr | ld_i | ld_fr | ld_rej | ld_poll));
      poll_p_r  <= (exp_conn & ~limit_hit) | (poll_p_r & ~ld_poll & ~limit_hit);
    end
  end

  // ==========================================================================
  // Sequence variables, link state and retransmission count
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= lls_pkg::LS_DISC;
      vs_r        <= 3'h0;
      vr_r        <= 3'h0;
      va_r        <= 3'h0;
      x_r         <= 3'h0;
      top_r       <= 3'h0;
      retry_r     <= 8'h00;
      peer_busy_r <= 1'b0;
    end else begin
      if (ld_i) begin
        vs_r <= 3'(vs_r + 3'h1);
        if (vs_r == top_r) begin
          top_r <= 3'(top_r + 3'h1);
        end
      end
      if (i_accept) begin
        vr_r <= 3'(vr_r + 3'h1);
      end
      if (new_ack) begin
        va_r    <= rx_nr;
        retry_r <= 8'h00;
      end
      if (conn && rx_rnr) begin
        peer_busy_r <= 1'b1;
        retry_r     <= 8'h00;
      end
      if (conn && (rx_rr || rx_rej)) begin
        peer_busy_r <= 1'b0;
      end
      if (conn && rx_rej) begin
        vs_r <= rx_nr;
      end
      if (recov_hit) begin
        state_r <= lls_pkg::LS_XFER;
        vs_r    <= rx_nr;
      end
      if (t1_exp && in_setup) begin
        if (retry_r < n1) begin
          retry_r <= 8'(retry_r + 8'h01);
        end else begin
          state_r <= lls_pkg::LS_DISC;
        end
      end else if (exp_conn) begin
        state_r <= lls_pkg::LS_RECOV;
        retry_r <= 8'(retry_r + 8'h01);
        x_r     <= vs_r;
      end
      if (limit_hit || connect_r) begin
        state_r <= lls_pkg::LS_SETUP;
        retry_r <= 8'h00;
      end
      if (in_setup && rx_ua) begin
        state_r <= lls_pkg::LS_XFER;
        vs_r    <= 3'h0;
        vr_r    <= 3'h0;
        va_r    <= 3'h0;
        top_r   <= 3'h0;
        retry_r <= 8'h00;
      end
      if (rx_sabm) begin
        state_r     <= lls_pkg::LS_XFER;
        vs_r        <= 3'h0;
        vr_r        <= 3'h0;
        va_r        <= 3'h0;
        top_r       <= 3'h0;
        retry_r     <= 8'h00;
        peer_busy_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Upward indication and T1
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_valid_r <= 1'b0;
      up_empty_r <= 1'b0;
    end else begin
      up_valid_r <= i_accept;
      if (i_accept) begin
        up_empty_r <= rx_frame.empty;
      end
    end
  end

  assign t1_start = ld_sabm | ld_poll | (ld_i & ~t1_run)
                    | (new_ack & rx_nr != top_r);
  assign t1_stop  = (in_setup & rx_ua) | (new_ack & rx_nr == top_r) | rx_sabm;

  lls_t1_timer u_t1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .start   (t1_start),
    .stop    (t1_stop),
    .period  (t1_cfg_r[15:0]),
    .running (t1_run),
    .expire  (t1_exp)
  );

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  logic        aw_h_r, w_h_r, bvalid_r, rvalid_r;
  logic [7:0]  aw_a_r;
  logic [31:0] w_d_r, rdata_r, wmask, rd_mux, stat;
  logic [3:0]  w_s_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        do_wr, wr_hit, rd_hit;

  assign do_wr  = aw_h_r && w_h_r && !bvalid_r;
  assign wmask  = {{8{w_s_r[3]}}, {8{w_s_r[2]}}, {8{w_s_r[1]}}, {8{w_s_r[0]}}};
  assign wr_hit = aw_a_r == lls_pkg::OFS_CTRL || aw_a_r == lls_pkg::OFS_T1
                  || aw_a_r == lls_pkg::OFS_LIM || aw_a_r == lls_pkg::OFS_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      aw_a_r   <= 8'h00;
      w_d_r    <= 32'h0000_0000;
      w_s_r    <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= lls_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_h_r) begin
        aw_h_r <= 1'b1;
        aw_a_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_h_r) begin
        w_h_r <= 1'b1;
        w_d_r <= s_axi_wdata;
        w_s_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_h_r   <= 1'b0;
        w_h_r    <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? lls_pkg::RESP_OKAY : lls_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // The connect bit is a write-one strobe and always reads back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= lls_pkg::CTRL_RST;
      t1_cfg_r  <= lls_pkg::T1_RST;
      lim_r     <= lls_pkg::LIM_RST;
      addr_r    <= lls_pkg::ADDR_RST;
      connect_r <= 1'b0;
    end else begin
      connect_r <= do_wr && aw_a_r == lls_pkg::OFS_CTRL
                   && w_s_r[0] && w_d_r[lls_pkg::CTRL_CONNECT];
      if (do_wr && aw_a_r == lls_pkg::OFS_CTRL) begin
        ctrl_r <= ((ctrl_r & ~wmask) | (w_d_r & wmask)) & 32'h0000_0006;
      end
      if (do_wr && aw_a_r == lls_pkg::OFS_T1) begin
        t1_cfg_r <= ((t1_cfg_r & ~wmask) | (w_d_r & wmask)) & 32'h0000_FFFF;
      end
      if (do_wr && aw_a_r == lls_pkg::OFS_LIM) begin
        lim_r <= ((lim_r & ~wmask) | (w_d_r & wmask)) & 32'h0000_FFFF;
      end
      if (do_wr && aw_a_r == lls_pkg::OFS_ADDR) begin
        addr_r <= (addr_r & ~wmask) | (w_d_r & wmask);
      end
    end
  end

  always_comb begin
    stat = 32'h0000_0000;
    stat[lls_pkg::ST_STATE +: 4] = state_r;
    stat[lls_pkg::ST_PBUSY]      = peer_busy_r;
    stat[lls_pkg::ST_T1RUN]      = t1_run;
    stat[lls_pkg::ST_VS +: 3]    = vs_r;
    stat[lls_pkg::ST_VR +: 3]    = vr_r;
    stat[lls_pkg::ST_VA +: 3]    = va_r;
    stat[lls_pkg::ST_RETRY +: 8] = retry_r;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      lls_pkg::OFS_CTRL: rd_mux = ctrl_r;
      lls_pkg::OFS_T1:   rd_mux = t1_cfg_r;
      lls_pkg::OFS_LIM:  rd_mux = lim_r;
      lls_pkg::OFS_ADDR: rd_mux = addr_r;
      lls_pkg::OFS_STAT: rd_mux = stat;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= lls_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? lls_pkg::RESP_OKAY : lls_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_h_r;
  assign s_axi_wready  = !w_h_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign tx_valid      = tx_valid_r;
  assign tx_frame      = tx_r;
  assign i_take        = i_take_r;
  assign i_seq         = i_seq_r;
  assign up_valid      = up_valid_r;
  assign up_empty      = up_empty_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ua_setup;
    in_setup && rx_ua;
  endsequence

  sequence s_in_order;
    i_accept && !rx_sabm;
  endsequence

  a_sabm_arms_t1: assert property (ld_sabm |=> t1_run)
    else $error("T1 not running after SABM queued");
  a_ua_zeroes: assert property (s_ua_setup |=> in_xfer && vs_r == 3'h0 && vr_r == 3'h0 && !t1_run)
    else $error("UA did not zero variables or stop T1");
  a_sabm_retry: assert property (exp_setup && !rx_ua && !connect_r && !rx_sabm
    |=> sabm_p_r && retry_r == 8'($past(retry_r) + 8'h01))
    else $error("SABM not resent on T1 expiry");
  a_ns_tracks_vs: assert property (ld_i |=> tx_frame.ns == $past(vs_r) && tx_valid)
    else $error("I frame N(S) differs from V(S)");
  a_window_held: assert property (ld_i |-> 3'(vs_r - va_r) != 3'h7)
    else $error("I frame sent with full window");
  a_frmr_silent: assert property (frmr |-> !ld_i)
    else $error("I frame sent in frame-reject mode");
  a_accept_inorder: assert property (s_in_order |=> up_valid && vr_r == 3'($past(vr_r) + 3'h1))
    else $error("In-order I frame not accepted");
  a_rej_seq: assert property (ld_rej |=> tx_frame.kind == lls_pkg::FK_REJ && tx_frame.nr == $past(vr_r))
    else $error("REJ carries wrong N(R)");
  a_recov_entry: assert property (exp_conn && !limit_hit && !rx_sabm && !connect_r && !recov_hit
    |=> in_recov && x_r == $past(vs_r))
    else $error("T1 expiry did not enter recovery");
  a_reset_on_n2: assert property (limit_hit && !rx_sabm |=> in_setup && sabm_p_r)
    else $error("N2 reached without link reset");
endmodule
`default_nettype wire

//--- testbench/lls_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lls_peer (
  input  wire logic             aclk,
  input  wire logic             slow,
  input  wire logic             tx_valid,
  input  wire lls_pkg::lls_tx_s tx_frame,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output lls_pkg::lls_rx_s      rx_frame,
  input  wire logic             inj,
  input  wire lls_pkg::lls_rx_s inj_f,
  output lls_pkg::lls_tx_s      last,
  output int                    n_i
);
  // ====
  // Takes frames, stalling every other cycle when slow, and answers a SABM with UA.
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
    last = '0;
    n_i = 0;
  end
  always @(posedge aclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    rx_valid <= inj;
    rx_frame <= inj ? inj_f : ~rx_frame;
    if (tx_valid && tx_ready) begin
      last <= tx_frame;
      if (tx_frame.kind == lls_pkg::FK_I)
        n_i <= n_i + 1;
      if (tx_frame.kind == lls_pkg::FK_SABM) begin
        rx_valid <= 1'b1;
        rx_frame <= {lls_pkg::FK_UA, 9'h006};
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/lls_link_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lls_link_sequencer_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_valid, tx_ready, rx_valid;
  logic i_avail, i_take, up_valid, up_empty, slow, inj, seen, proto_tick;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, d;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r;
  logic [2:0]       i_seq;
  lls_pkg::lls_rx_s rx_frame, inj_f;
  lls_pkg::lls_tx_s tx_frame, last;
  int               error_cnt, n_tests, cyc, n_i, n_take;
  lls_link_sequencer i_lls_link_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .proto_tick, .rx_valid, .rx_frame, .tx_valid, .tx_ready,
    .tx_frame, .i_avail, .i_take, .i_seq, .up_valid, .up_empty);
  lls_peer i_lls_peer (.aclk, .slow, .tx_valid, .tx_frame, .tx_ready, .rx_valid, .rx_frame, .inj,
    .inj_f, .last, .n_i);
  // ====
  // Bus master and comparison.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic t, ar;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rx_i(input lls_pkg::lls_rx_s f);
    @(posedge aclk);
    inj <= 1'b1;
    inj_f <= f;
    @(posedge aclk);
    inj <= 1'b0;
    seen = 1'b0;
    repeat (30) @(negedge aclk) seen |= up_valid;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // Scenarios.
  task automatic t_regs();
    rd(lls_pkg::OFS_T1); chk("t1", d, 32'h0000_0010);
    rd(lls_pkg::OFS_LIM); chk("lim", d, 32'h0000_0A0A);
    rd(8'h20); chk("unmapped", {30'h0, r}, {30'h0, lls_pkg::RESP_SLVERR});
    wr(lls_pkg::OFS_T1, 32'h0000_0003);
    rd(lls_pkg::OFS_T1); chk("t1 wr", d, 32'h0000_0003);
    $display("done regs");
  endtask
  task automatic t_connect();
    wr(lls_pkg::OFS_ADDR, 32'h00A2_00B1);
    wr(lls_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (30) @(posedge aclk);
    chk("sabm", {last.kind, last.pf}, {lls_pkg::FK_SABM, 1'b1});
    chk("addr", {last.dst, last.src}, 32'h00B1_00A2);
    rd(lls_pkg::OFS_STAT); chk("stat", {d[14:8], d[5:0]}, 13'h0004);
    $display("done connect");
  endtask
  task automatic t_window();
    slow <= 1'b1;
    i_avail <= 1'b1;
    repeat (200) @(negedge aclk) n_take += i_take;
    chk("frames", n_i, 32'h0000_0007);
    chk("seq", {29'h0, i_seq}, 32'h0000_0006);
    chk("takes", n_take, 32'h0000_0007);
    @(posedge aclk);
    i_avail <= 1'b0;
    rd(lls_pkg::OFS_STAT); chk("vs", {29'h0, d[10:8]}, 32'h0000_0007);
    $display("done window");
  endtask
  // Three protocol ticks expire T1 with seven frames outstanding.
  task automatic t_recover();
    repeat (6) begin
      repeat (3) @(posedge aclk);
      proto_tick <= !proto_tick;
    end
    repeat (20) @(posedge aclk);
    chk("poll", {last.kind, last.pf}, {lls_pkg::FK_RR, 1'b1});
    rd(lls_pkg::OFS_STAT); chk("recov", {d[31:24], d[5:0]}, 14'h0068);
    rx_i({lls_pkg::FK_RR, 3'h0, 3'h7, 3'h6});
    rd(lls_pkg::OFS_STAT); chk("retry clr", {24'h0, d[31:24]}, 32'h0000_0000);
    chk("recov end", {d[18:16], d[10:8], d[5:0]}, 12'hFC4);
    $display("done recover");
  endtask
  task automatic t_receive();
    rx_i({lls_pkg::FK_I, 3'h0, 3'h7, 3'h3}); chk("up", {31'h0, seen}, 32'h0000_0001);
    chk("empty", {31'h0, up_empty}, 32'h0000_0001);
    chk("rr", {last.kind, last.nr}, {lls_pkg::FK_RR, 3'h1});
    rx_i({lls_pkg::FK_I, 3'h3, 3'h7, 3'h2}); chk("rej", {last.kind, last.nr}, {lls_pkg::FK_REJ, 3'h1});
    $display("done receive");
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, i_avail, slow, inj, inj_f, proto_tick} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_connect();
    t_window();
    t_recover();
    t_receive();
    summarize();
  end
endmodule
`default_nettype wire
